// ==== hw/probe_cmd_map.svh ====
// offsets, packet layout, reset values and limits of the probe command decoder
`ifndef PROBE_CMD_MAP_SVH
`define PROBE_CMD_MAP_SVH

// apb register byte offsets
`define REG_CTRL_OFS        8'h00
`define REG_STATUS_OFS      8'h04
`define REG_GOOD_CNT_OFS    8'h08
`define REG_BAD_CNT_OFS     8'h0C
`define REG_AIR_SPEED_OFS   8'h10
`define REG_HEATER_EN_OFS   8'h14

// register fields and reset values
`define CTRL_DECODE_EN_BIT  0
`define CTRL_RESET_VAL      1'h1
`define STATUS_CMD_LSB      8

// packet framing
`define FLAG_CHAR_C         8'h43
`define FLAG_CHAR_U         8'h55
`define CMD_SET_MASK        8'h01
`define CMD_AIR_SPEED       8'h02
`define CMD_CONTROL         8'h03
`define LEN_SET_MASK        8'h24
`define LEN_AIR_SPEED       8'h08
`define LEN_CONTROL         8'h42
// last position covered by the control checksum, as printed
`define CTRL_CSUM_LAST      7'h25

// character positions inside a packet (1-based)
`define POS_MASK_H          4
`define POS_MASK_V          20
`define POS_AIR_SPEED       4
`define POS_HEAT_EN_LO      4
`define POS_HEAT_EN_HI      5
`define POS_MODE            6
`define POS_THRESH          8
`define POS_H_LASER_PWR     34
`define POS_V_LASER_PWR     36
`define POS_AM_H_MAX        38
`define POS_AM_H_REJ        40
`define POS_AM_H_MIN        42
`define POS_AM_V_MAX        44
`define POS_AM_V_REJ        46
`define POS_AM_V_MIN        48
`define POS_BLOCKS          50
`define POS_TX_DIV          52
`define POS_PID_P           56
`define POS_PID_I           58

// mode byte fields
`define MODE_BUILD_H_BIT    0
`define MODE_BUILD_V_BIT    1
`define MODE_COMP_LSB       2
`define MODE_H_MANUAL_BIT   4
`define MODE_V_MANUAL_BIT   5

// value limits and defaults
`define THRESH_MIN          (-17'sd2040)
`define THRESH_MAX          (17'sd2040)
`define LASER_PWR_MIN       (17'sd0)
`define LASER_PWR_MAX       (17'sd4095)
`define DEF_AM_MAX_SLICES   16'h0064
`define DEF_AM_REJECT_PCT   16'h00C8
`define DEF_AM_MIN_SLICES   16'h0001
`define DEF_BLOCKS_PER_SEC  16'h0050
`define DEF_TX_DIVIDER      16'h0009
// consumers divide the pid gain words by this before use as float
`define PID_GAIN_DIVISOR    32'h0098_9680

`endif

// ==== hw/probe_cmd_pkg.sv ====
// types shared by the probe command decoder
package probe_cmd_pkg;

    typedef enum logic [1:0] {
        ST_HUNT = 2'b00,
        ST_LEN  = 2'b01,
        ST_CMD  = 2'b10,
        ST_BODY = 2'b11
    } decode_state_t;

    typedef enum logic [1:0] {
        COMP_STEREO = 2'b00,
        COMP_BOTH   = 2'b01,
        COMP_HORIZ  = 2'b10,
        COMP_VERT   = 2'b11
    } compress_mode_t;

    typedef logic [15:0] word_t;

endpackage

// ==== hw/word_limit.sv ====
// clamps a received 16-bit word into a fixed window
`timescale 1ns/100ps
module word_limit #(
    parameter logic signed [16:0] LO        = -17'sd2040,
    parameter logic signed [16:0] HI        = 17'sd2040,
    parameter bit                 IS_SIGNED = 1'b1
) (
    input  logic [15:0] in_word,
    output logic [15:0] out_word
);
    logic signed [16:0] ext;

    // widen by one bit so signed and unsigned words compare alike
    always_comb begin
        ext = IS_SIGNED ? {in_word[15], in_word} : {1'b0, in_word};
        if (ext < LO) begin
            out_word = LO[15:0];
        end else if (ext > HI) begin
            out_word = HI[15:0];
        end else begin
            out_word = in_word;
        end
    end
endmodule // word_limit

// ==== hw/probe_command_decoder.sv ====
// command packet decoder with apb status and control registers
`timescale 1ns/100ps
`include "probe_cmd_map.svh"

// Functional notes
// - set-mask: C, 36, cmd 1, two masks, checksum
// - air-speed: C, 8, cmd 2, four chars, checksum
// - air-speed float assembled most significant first
// - control: U, 66, cmd 3, checksum at 66
// - chars 4/5 enable heater zones 0-12
// - each enable pairs with its threshold pair
// - mode bits 0/1 request mask builds
// - mode bits 2-3 select compression mode
// - mode bits 4/5 select laser auto/manual
// - sync bit 6 and bit 7 ignored
// - thirteen signed thresholds, limited to +-2040
// - laser powers at 34/36, limited 0-4095
// - integers travel high byte first
// - auto-mask max slices, default 100
// - auto-mask reject percent, default 2 percent
// - auto-mask min slices to run, default 1
// - positions 50-51 give blocks per second
// - positions 52-53 give transmit divider word
// - defaults 0x50 blocks and divider 9
// - pid gain words, consumers divide by 1e7
// - act only on verified checksum
module probe_command_decoder
    import probe_cmd_pkg::*;
(
    input  logic                         pclk,
    input  logic                         presetn,
    input  logic                         psel,
    input  logic                         penable,
    input  logic                         pwrite,
    input  logic [7:0]                   paddr,
    input  logic [31:0]                  pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  logic                         rx_valid,
    input  logic [7:0]                   rx_data,
    output logic [127:0]                 h_mask,
    output logic [127:0]                 v_mask,
    output logic                         mask_load,
    output logic [31:0]                  air_speed_clock,
    output logic                         air_speed_load,
    output logic [12:0]                  heater_en,
    output logic [12:0][15:0]            heater_thresh,
    output logic [15:0]                  h_laser_pwr,
    output logic [15:0]                  v_laser_pwr,
    output logic                         build_h_mask,
    output logic                         build_v_mask,
    output probe_cmd_pkg::compress_mode_t compress_mode,
    output logic                         h_laser_manual,
    output logic                         v_laser_manual,
    output logic [15:0]                  automask_max_slices_h,
    output logic [15:0]                  automask_reject_pct_h,
    output logic [15:0]                  automask_min_slices_run_h,
    output logic [15:0]                  automask_max_slices_v,
    output logic [15:0]                  automask_reject_pct_v,
    output logic [15:0]                  automask_min_slices_run_v,
    output logic [15:0]                  blocks_per_sec,
    output logic [15:0]                  tx_divider,
    output logic [15:0]                  pid_p_gain,
    output logic [15:0]                  pid_i_gain,
    output logic                         ctrl_load
);
    import probe_cmd_pkg::*;

    typedef struct packed {
        decode_state_t      state;
        logic [6:0]         pos;
        logic [7:0]         len;
        logic [7:0]         flag;
        logic [6:0]         csum_last;
        logic [7:0]         sum;
        logic [66:1][7:0]   pkt;
        logic               decode_en;
        logic [15:0]        good_cnt;
        logic [15:0]        bad_cnt;
        logic [7:0]         last_cmd;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic [127:0]       h_mask;
        logic [127:0]       v_mask;
        logic               mask_load;
        logic [31:0]        air_speed;
        logic               air_speed_load;
        logic [12:0]        heater_en;
        logic [12:0][15:0]  heater_thresh;
        logic [15:0]        h_laser_pwr;
        logic [15:0]        v_laser_pwr;
        logic               build_h;
        logic               build_v;
        compress_mode_t     comp_mode;
        logic               h_manual;
        logic               v_manual;
        logic [15:0]        am_h_max;
        logic [15:0]        am_h_rej;
        logic [15:0]        am_h_min;
        logic [15:0]        am_v_max;
        logic [15:0]        am_v_rej;
        logic [15:0]        am_v_min;
        logic [15:0]        blocks;
        logic [15:0]        tx_div;
        logic [15:0]        pid_p;
        logic [15:0]        pid_i;
        logic               ctrl_load;
    } dec_state_t;

    // reset image: only the documented defaults are non-zero
    localparam dec_state_t RESET_VAL = '{
        state     : ST_HUNT,
        decode_en : `CTRL_RESET_VAL,
        comp_mode : COMP_STEREO,
        am_h_max  : `DEF_AM_MAX_SLICES,
        am_h_rej  : `DEF_AM_REJECT_PCT,
        am_h_min  : `DEF_AM_MIN_SLICES,
        am_v_max  : `DEF_AM_MAX_SLICES,
        am_v_rej  : `DEF_AM_REJECT_PCT,
        am_v_min  : `DEF_AM_MIN_SLICES,
        blocks    : `DEF_BLOCKS_PER_SEC,
        tx_div    : `DEF_TX_DIVIDER,
        default   : '0
    };

    dec_state_t         s_r;
    dec_state_t         s_nxt;
    logic [12:0][15:0]  thresh_lim;
    logic [15:0]        h_pwr_lim;
    logic [15:0]        v_pwr_lim;

    // threshold words are limited as they leave the buffer, high byte first
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++) begin : g_thresh
            word_limit #(
                .LO        (`THRESH_MIN),
                .HI        (`THRESH_MAX),
                .IS_SIGNED (1'b1)
            ) u_thresh_lim (
                .in_word  ({s_r.pkt[`POS_THRESH + 2*gi],
                            s_r.pkt[`POS_THRESH + 2*gi + 1]}),
                .out_word (thresh_lim[gi])
            );
        end
    endgenerate

    // laser power is unsigned, so a word above 0x7FFF clamps high not low
    word_limit #(
        .LO        (`LASER_PWR_MIN),
        .HI        (`LASER_PWR_MAX),
        .IS_SIGNED (1'b0)
    ) u_h_pwr_lim (
        .in_word  ({s_r.pkt[`POS_H_LASER_PWR], s_r.pkt[`POS_H_LASER_PWR + 1]}),
        .out_word (h_pwr_lim)
    );

    word_limit #(
        .LO        (`LASER_PWR_MIN),
        .HI        (`LASER_PWR_MAX),
        .IS_SIGNED (1'b0)
    ) u_v_pwr_lim (
        .in_word  ({s_r.pkt[`POS_V_LASER_PWR], s_r.pkt[`POS_V_LASER_PWR + 1]}),
        .out_word (v_pwr_lim)
    );

    // big-endian word at a packet position
    function automatic word_t be_word(input logic [66:1][7:0] pk, input int p);
        be_word = {pk[p], pk[p + 1]};
    endfunction

    // next-state logic: apb slave first so that counter increments win over clears
    always_comb begin
        logic [6:0] p;
        logic [7:0] mode;
        p    = s_r.pos + 7'h01;
        mode = s_r.pkt[`POS_MODE];
        s_nxt                = s_r;
        s_nxt.pready         = 1'b0;
        s_nxt.pslverr        = 1'b0;
        s_nxt.mask_load      = 1'b0;
        s_nxt.air_speed_load = 1'b0;
        s_nxt.ctrl_load      = 1'b0;
        s_nxt.build_h        = 1'b0;
        s_nxt.build_v        = 1'b0;

        // setup phase: read data and error are registered, zero wait states
        if (psel && !penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0000_0000;
            unique case (paddr)
                `REG_CTRL_OFS:      s_nxt.prdata[`CTRL_DECODE_EN_BIT] = s_r.decode_en;
                `REG_STATUS_OFS:    s_nxt.prdata = {16'h0000, s_r.last_cmd, 6'h00, s_r.state};
                `REG_GOOD_CNT_OFS:  s_nxt.prdata = {16'h0000, s_r.good_cnt};
                `REG_BAD_CNT_OFS:   s_nxt.prdata = {16'h0000, s_r.bad_cnt};
                `REG_AIR_SPEED_OFS: s_nxt.prdata = s_r.air_speed;
                `REG_HEATER_EN_OFS: s_nxt.prdata = {19'h00000, s_r.heater_en};
                default:            s_nxt.pslverr = 1'b1;
            endcase
        end

        // access phase: write lands on the edge that samples pready high
        if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
            unique case (paddr)
                `REG_CTRL_OFS:     s_nxt.decode_en = pwdata[`CTRL_DECODE_EN_BIT];
                `REG_GOOD_CNT_OFS: s_nxt.good_cnt = 16'h0000;
                `REG_BAD_CNT_OFS:  s_nxt.bad_cnt = 16'h0000;
                default: ;
            endcase
        end

        // disabling mid-packet drops it, nothing half-decoded is applied
        if (!s_r.decode_en) begin
            s_nxt.state = ST_HUNT;
        end else if (rx_valid) begin
            unique case (s_r.state)
                ST_HUNT: begin
                    // anything but a flag is line noise while hunting
                    if (rx_data == `FLAG_CHAR_C || rx_data == `FLAG_CHAR_U) begin
                        s_nxt.pkt[1] = rx_data;
                        s_nxt.flag   = rx_data;
                        s_nxt.sum    = rx_data;
                        s_nxt.pos    = 7'h01;
                        s_nxt.state  = ST_LEN;
                    end
                end
                ST_LEN: begin
                    s_nxt.pkt[2] = rx_data;
                    s_nxt.len    = rx_data;
                    s_nxt.sum    = s_r.sum + rx_data;
                    s_nxt.pos    = 7'h02;
                    s_nxt.state  = ST_CMD;
                end
                ST_CMD: begin
                    s_nxt.pkt[3] = rx_data;
                    s_nxt.sum    = s_r.sum + rx_data;
                    s_nxt.pos    = 7'h03;
                    s_nxt.state  = ST_BODY;
                    if (s_r.flag == `FLAG_CHAR_C && rx_data == `CMD_SET_MASK &&
                        s_r.len == `LEN_SET_MASK) begin
                        s_nxt.csum_last = 7'(`LEN_SET_MASK - 8'h01);
                    end else if (s_r.flag == `FLAG_CHAR_C && rx_data == `CMD_AIR_SPEED &&
                                 s_r.len == `LEN_AIR_SPEED) begin
                        s_nxt.csum_last = 7'(`LEN_AIR_SPEED - 8'h01);
                    end else if (s_r.flag == `FLAG_CHAR_U && rx_data == `CMD_CONTROL &&
                                 s_r.len == `LEN_CONTROL) begin
                        s_nxt.csum_last = `CTRL_CSUM_LAST;
                    end else begin
                        // unknown combination: drop and look for the next flag
                        s_nxt.bad_cnt = s_nxt.bad_cnt + 16'h0001;
                        s_nxt.state   = ST_HUNT;
                    end
                end
                ST_BODY: begin
                    s_nxt.pkt[p] = rx_data;
                    s_nxt.pos    = p;
                    if ({1'b0, p} != s_r.len) begin
                        if (p <= s_r.csum_last) begin
                            s_nxt.sum = s_r.sum + rx_data;
                        end
                    end else begin
                        s_nxt.state = ST_HUNT;
                        // a failed checksum leaves every setting untouched
                        if (rx_data != s_r.sum) begin
                            s_nxt.bad_cnt = s_nxt.bad_cnt + 16'h0001;
                        end else begin
                            s_nxt.good_cnt = s_nxt.good_cnt + 16'h0001;
                            s_nxt.last_cmd = s_r.pkt[3];
                            unique case (s_r.pkt[3])
                                `CMD_SET_MASK: begin
                                    // first mask character lands in the top byte
                                    for (int i = 0; i < 16; i++) begin
                                        s_nxt.h_mask[127 - 8*i -: 8] = s_r.pkt[`POS_MASK_H + i];
                                        s_nxt.v_mask[127 - 8*i -: 8] = s_r.pkt[`POS_MASK_V + i];
                                    end
                                    s_nxt.mask_load = 1'b1;
                                end
                                `CMD_AIR_SPEED: begin
                                    s_nxt.air_speed = {s_r.pkt[`POS_AIR_SPEED],
                                                       s_r.pkt[`POS_AIR_SPEED + 1],
                                                       s_r.pkt[`POS_AIR_SPEED + 2],
                                                       s_r.pkt[`POS_AIR_SPEED + 3]};
                                    s_nxt.air_speed_load = 1'b1;
                                end
                                default: begin
                                    // spare bits 5-7 of the high enable byte dropped
                                    s_nxt.heater_en = {s_r.pkt[`POS_HEAT_EN_HI][4:0],
                                                       s_r.pkt[`POS_HEAT_EN_LO]};
                                    s_nxt.heater_thresh = thresh_lim;
                                    s_nxt.build_h  = mode[`MODE_BUILD_H_BIT];
                                    s_nxt.build_v  = mode[`MODE_BUILD_V_BIT];
                                    s_nxt.comp_mode =
                                        compress_mode_t'(mode[`MODE_COMP_LSB +: 2]);
                                    s_nxt.h_manual = mode[`MODE_H_MANUAL_BIT];
                                    s_nxt.v_manual = mode[`MODE_V_MANUAL_BIT];
                                    // bits 6 and 7 of the mode byte have no consumer
                                    s_nxt.h_laser_pwr = h_pwr_lim;
                                    s_nxt.v_laser_pwr = v_pwr_lim;
                                    s_nxt.am_h_max = be_word(s_r.pkt, `POS_AM_H_MAX);
                                    s_nxt.am_v_max = be_word(s_r.pkt, `POS_AM_V_MAX);
                                    s_nxt.am_h_rej = be_word(s_r.pkt, `POS_AM_H_REJ);
                                    s_nxt.am_v_rej = be_word(s_r.pkt, `POS_AM_V_REJ);
                                    s_nxt.am_h_min = be_word(s_r.pkt, `POS_AM_H_MIN);
                                    s_nxt.am_v_min = be_word(s_r.pkt, `POS_AM_V_MIN);
                                    s_nxt.blocks   = be_word(s_r.pkt, `POS_BLOCKS);
                                    // divider is passed on though nothing downstream needs it
                                    s_nxt.tx_div   = be_word(s_r.pkt, `POS_TX_DIV);
                                    s_nxt.pid_p    = be_word(s_r.pkt, `POS_PID_P);
                                    s_nxt.pid_i    = be_word(s_r.pkt, `POS_PID_I);
                                    s_nxt.ctrl_load = 1'b1;
                                end
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    // single state register; defaults come back with every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= RESET_VAL;
        end else begin
            s_r <= s_nxt;
        end
    end

    // all outputs are plain views of the state register
    assign prdata                    = s_r.prdata;
    assign pready                    = s_r.pready;
    assign pslverr                   = s_r.pslverr;
    assign h_mask                    = s_r.h_mask;
    assign v_mask                    = s_r.v_mask;
    assign mask_load                 = s_r.mask_load;
    assign air_speed_clock           = s_r.air_speed;
    assign air_speed_load            = s_r.air_speed_load;
    assign heater_en                 = s_r.heater_en;
    assign heater_thresh             = s_r.heater_thresh;
    assign h_laser_pwr               = s_r.h_laser_pwr;
    assign v_laser_pwr               = s_r.v_laser_pwr;
    assign build_h_mask              = s_r.build_h;
    assign build_v_mask              = s_r.build_v;
    assign compress_mode             = s_r.comp_mode;
    assign h_laser_manual            = s_r.h_manual;
    assign v_laser_manual            = s_r.v_manual;
    assign automask_max_slices_h     = s_r.am_h_max;
    assign automask_reject_pct_h     = s_r.am_h_rej;
    assign automask_min_slices_run_h = s_r.am_h_min;
    assign automask_max_slices_v     = s_r.am_v_max;
    assign automask_reject_pct_v     = s_r.am_v_rej;
    assign automask_min_slices_run_v = s_r.am_v_min;
    assign blocks_per_sec            = s_r.blocks;
    assign tx_divider                = s_r.tx_div;
    assign pid_p_gain                = s_r.pid_p;
    assign pid_i_gain                = s_r.pid_i;
    assign ctrl_load                 = s_r.ctrl_load;

endmodule // probe_command_decoder

// ==== verification/probe_cmd_chk.sv ====
// port-level assertions for the probe command decoder
`timescale 1ns/100ps
module probe_cmd_chk (
    input logic              pclk,
    input logic              presetn,
    input logic              psel,
    input logic              penable,
    input logic              pready,
    input logic              rx_valid,
    input logic              mask_load,
    input logic              air_speed_load,
    input logic              ctrl_load,
    input logic              build_h_mask,
    input logic              build_v_mask,
    input logic [31:0]       air_speed_clock,
    input logic [12:0]       heater_en,
    input logic [12:0][15:0] heater_thresh,
    input logic [15:0]       h_laser_pwr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // an air-speed load follows the taken checksum byte and lasts one cycle
    sequence s_after_byte;
        $past(rx_valid) ##1 !air_speed_load;
    endsequence
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_MASK_PULSE: assert property (mask_load |=> !mask_load)
        else $error("mask load longer than one cycle");
    AST_SPEED_CAUSE: assert property (air_speed_load |-> s_after_byte)
        else $error("speed load not tied to a taken byte");
    AST_SPEED_HOLD: assert property (!air_speed_load |-> $stable(air_speed_clock))
        else $error("air speed changed without load");
    AST_HEAT_HOLD: assert property (!ctrl_load |-> $stable(heater_en))
        else $error("heater enables changed without load");
    AST_BUILD_H: assert property (build_h_mask |-> ctrl_load)
        else $error("horizontal build outside control load");
    AST_BUILD_V: assert property (build_v_mask |-> ctrl_load ##1 !build_v_mask)
        else $error("vertical build not a control pulse");
    AST_THRESH_LIM: assert property ($signed(heater_thresh[12]) >= -2040 &&
        $signed(heater_thresh[12]) <= 2040)
        else $error("threshold outside window");
    AST_LASER_LIM: assert property (h_laser_pwr <= 16'h0FFF)
        else $error("laser power above limit");
endmodule // probe_cmd_chk
bind probe_command_decoder probe_cmd_chk u_chk (.*);

// ==== verification/data_system_model.sv ====
// behavioural data system streaming command packets into the decoder
`timescale 1ns/100ps
module data_system_model (
    input  logic       pclk,
    output logic       rx_valid,
    output logic [7:0] rx_data
);
    logic [7:0] pkt [1:66];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end
    // checksum is the modulo-256 sum of the covered characters
    task automatic send(input int n, input int last, input logic [7:0] adj);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 1; i <= last; i++) s += pkt[i];
        pkt[n] = s + adj;
        for (int i = 1; i <= n; i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_data  <= pkt[i];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        // idle data inverted so a stale byte never looks valid
        rx_data  <= ~pkt[n];
    endtask
endmodule // data_system_model

// ==== verification/probe_command_decoder_bench.sv ====
// self-checking bench for the probe command decoder
`timescale 1ns/100ps
module probe_command_decoder_bench;
    import probe_cmd_pkg::*;
    logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic              pwrite = 1'b0, pready, pslverr, rx_valid, err;
    logic [7:0]        paddr = 8'h00, rx_data;
    logic [31:0]       pwdata = 32'h0, prdata, air_speed_clock, rd;
    logic              mask_load, air_speed_load, ctrl_load, build_h_mask, build_v_mask;
    logic              h_laser_manual, v_laser_manual;
    logic [127:0]      h_mask, v_mask;
    logic [12:0]       heater_en;
    logic [12:0][15:0] heater_thresh;
    logic [15:0]       h_laser_pwr, v_laser_pwr, blocks_per_sec, tx_divider;
    logic [15:0]       pid_p_gain, pid_i_gain;
    logic [15:0]       automask_max_slices_h, automask_reject_pct_h, automask_min_slices_run_h;
    logic [15:0]       automask_max_slices_v, automask_reject_pct_v, automask_min_slices_run_v;
    compress_mode_t    compress_mode;
    int                err_count = 0, checks = 0, cyc = 0;

    probe_command_decoder dut (.*);
    data_system_model dte (.*);

    always #50 pclk = ~pclk;
    // hang guard, the run needs well under this many cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic put(input int at, input logic [31:0] v);
        for (int i = 0; i < 4; i++) dte.pkt[at + i] = v[31 - 8 * i -: 8];
    endtask
    task automatic settle();
        repeat (20) begin
            @(posedge pclk);
            if (mask_load | air_speed_load | ctrl_load) break;
        end
    endtask
    task automatic t_defaults();
        chk({automask_max_slices_h, automask_max_slices_v,
             automask_reject_pct_h, automask_reject_pct_v, automask_min_slices_run_h,
             automask_min_slices_run_v, blocks_per_sec, tx_divider},
            128'h0064_0064_00C8_00C8_0001_0001_0050_0009);
    endtask
    task automatic t_speed();
        put(1, 32'h4308_0241);
        put(5, 32'h2000_0000);
        dte.send(8, 7, 8'h00);
        settle();
        chk(air_speed_clock, 32'h4120_0000);
        put(4, 32'h3F80_0000);
        dte.send(8, 7, 8'h01);
        settle();
        chk(air_speed_clock, 32'h4120_0000);
    endtask
    task automatic t_mask();
        put(1, 32'h4308_0000);
        dte.send(3, 2, 8'h00);
        put(1, 32'h4324_0100);
        for (int i = 4; i <= 35; i++) dte.pkt[i] = 8'(i);
        dte.send(36, 35, 8'h00);
        settle();
        chk({h_mask[127:120], h_mask[7:0], v_mask[127:120], v_mask[7:0]},
            32'h0413_1423);
    endtask
    task automatic t_ctrl(input logic [1:0] m);
        for (int i = 1; i <= 65; i++) dte.pkt[i] = 8'h00;
        put(1, 32'h5542_03A5);
        put(5, {8'hFF, 2'b01, m[1], m[0], m, m[0], ~m[0], 16'h0010});
        put(32, 32'hF000_FFFF);
        put(36, 32'h0123_007B);
        put(50, 32'h0020_0000); // fast divider for 32 blocks
        put(56, 32'h1234_5678);
        dte.send(66, 37, 8'h00);
        settle();
        chk({build_h_mask, build_v_mask, compress_mode, h_laser_manual, v_laser_manual},
            {~m[0], m[0], m, m[0], m[1]});
        chk({heater_en, heater_thresh[0], heater_thresh[12]},
            {13'h1FA5, 32'h07F8_F808});
        chk({h_laser_pwr, v_laser_pwr}, 32'h0FFF_0123);
        chk({automask_max_slices_h, blocks_per_sec, tx_divider, pid_p_gain, pid_i_gain},
            80'h007B_0020_0000_1234_5678);
    endtask
    task automatic t_regs();
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h6);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h4120_0000);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h1FA5);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
    endtask

    task automatic t_reset();
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_defaults();
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_defaults();
        t_speed();
        t_mask();
        for (int i = 0; i < 4; i++) t_ctrl(i[1:0]);
        t_regs();
        t_reset();
        finish_test();
    end
endmodule // probe_command_decoder_bench
